// ---- ise_pkg.sv ----
// constants, types and decode helpers for the instruction subset execute block
// assumes a single system clock and a 32-bit apb register bus
package ise_pkg;

  // --------------------------------------------------
  // program counter and data widths
  // --------------------------------------------------
  localparam int ISE_PC_W = 13;
  localparam int ISE_WORD_W = 14;
  localparam logic [12:0] ISE_RESET_PC = 13'h0000;
  localparam logic [12:0] ISE_IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] ISE_PC_STEP = 13'h0001;
  localparam logic [7:0] ISE_ACC_RST = 8'h00;
  localparam logic [4:0] ISE_LATCH_RST = 5'h00;

  // --------------------------------------------------
  // apb register map
  // --------------------------------------------------
  localparam logic [7:0] ISE_OFS_CTRL = 8'h00;
  localparam logic [7:0] ISE_OFS_LATCH = 8'h04;
  localparam logic [7:0] ISE_OFS_ACCUM = 8'h08;
  localparam logic [7:0] ISE_OFS_STAT = 8'h0c;
  localparam int ISE_CTRL_RUN = 0;
  localparam int ISE_CTRL_GIE = 1;
  localparam int ISE_STAT_ZERO = 16;
  localparam int ISE_STAT_SLEEP = 17;

  // --------------------------------------------------
  // operations and core states
  // --------------------------------------------------
  typedef enum logic [3:0] {
    ISE_OP_NOP = 4'h0,
    ISE_OP_TEST_BIT = 4'h1,
    ISE_OP_CALL = 4'h2,
    ISE_OP_JUMP = 4'h3,
    ISE_OP_CLEAR = 4'h4,
    ISE_OP_DEC_SKIP = 4'h5,
    ISE_OP_INC = 4'h6,
    ISE_OP_SWAP = 4'h7,
    ISE_OP_DIR_LOAD = 4'h8,
    ISE_OP_XOR_LIT = 4'h9,
    ISE_OP_XOR_REG = 4'ha,
    ISE_OP_SLEEP = 4'hb
  } ise_op_t;

  typedef enum logic [1:0] {
    ISE_IDLE = 2'b00,
    ISE_EXEC = 2'b01,
    ISE_SLEEP = 2'b10
  } ise_state_t;

  // class in bits 13:12 first, then the opcode fields below it
  function automatic ise_op_t iseDecode(input logic [13:0] w);
    ise_op_t o;
    o = ISE_OP_NOP;
    if (w[13:12] == 2'h1) begin
      if (w[11:10] == 2'h3) o = ISE_OP_TEST_BIT;
    end else if (w[13:12] == 2'h2) begin
      o = w[11] ? ISE_OP_JUMP : ISE_OP_CALL;
    end else if (w[13:12] == 2'h3) begin
      if (w[11:8] == 4'ha) o = ISE_OP_XOR_LIT;
    end else if (w[11:7] == 5'h03) o = ISE_OP_CLEAR;
    else if (w[11:8] == 4'hb) o = ISE_OP_DEC_SKIP;
    else if (w[11:8] == 4'ha) o = ISE_OP_INC;
    else if (w[11:8] == 4'he) o = ISE_OP_SWAP;
    else if (w[11:8] == 4'h6) o = ISE_OP_XOR_REG;
    else if (w[11:0] == 12'h063) o = ISE_OP_SLEEP;
    else if (w[11:3] == 9'h00c && w[2:0] >= 3'h5) o = ISE_OP_DIR_LOAD;
    return o;
  endfunction

  // operations whose bit 7 picks accumulator or register
  function automatic logic iseHasDest(input ise_op_t o);
    return o == ISE_OP_DEC_SKIP || o == ISE_OP_INC
        || o == ISE_OP_SWAP || o == ISE_OP_XOR_REG;
  endfunction

endpackage

// ---- ise_alu.sv ----
// result, zero-flag update and skip decision for one operation
// assumes the operand value is already forwarded and stable
`timescale 1ns/1ps
`default_nettype none

module ise_alu
  import ise_pkg::*;
(
  input wire ise_op_t op,
  input wire logic [7:0] fVal,
  input wire logic [7:0] acc,
  input wire logic [2:0] bitSel,
  input wire logic [7:0] lit,
  output logic [7:0] res,
  output logic zUpd,
  output logic skip
);

  always_comb begin
    res = fVal;
    zUpd = 1'b0;
    skip = 1'b0;
    unique case (op)
      ISE_OP_TEST_BIT: begin
        skip = fVal[bitSel];
      end
      ISE_OP_CLEAR: begin
        res = 8'h00;
        zUpd = 1'b1;
      end
      ISE_OP_DEC_SKIP: begin
        res = fVal - 8'h01;
        skip = (fVal == 8'h01);
      end
      ISE_OP_INC: begin
        res = fVal + 8'h01;
        zUpd = 1'b1;
      end
      ISE_OP_SWAP: begin
        res = {fVal[3:0], fVal[7:4]};
      end
      ISE_OP_XOR_LIT: begin
        res = acc ^ lit;
        zUpd = 1'b1;
      end
      ISE_OP_XOR_REG: begin
        res = acc ^ fVal;
        zUpd = 1'b1;
      end
      default: begin
        res = fVal;
      end
    endcase
  end

endmodule

`default_nettype wire

// ---- ise_core.sv ----
// execute core for a subset of an 8-bit instruction set, with apb control
// assumes program memory and register file reads are combinational
//
// Overview of operation
// - bit set: drop prefetch, run nop
// - call pushes pc+1, loads latched target
// - jump loads latched target, no push
// - clear writes zero, sets zero flag
// - decrement, skip on zero, flags untouched
// - destination bit: zero accumulator, one register
// - increment wraps, updates zero flag
// - swap nibbles, flags untouched
// - direction load copies accumulator, operand 5-7
// - xor literal into accumulator, zero flag
// - xor register to destination, zero flag
// - wake: vector if enabled, else inline
`timescale 1ns/1ps
`default_nettype none

module ise_core
  import ise_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [12:0] progAddr,
  input wire logic [13:0] progWord,
  output logic [6:0] regAddr,
  input wire logic [7:0] regRdData,
  output logic regWe,
  output logic [6:0] regWrAddr,
  output logic [7:0] regWrData,
  output logic stackPush,
  output logic [12:0] stackData,
  output logic dirWe,
  output logic [2:0] dirSel,
  output logic [7:0] dirData,
  input wire logic wakeIrq
);

  // --------------------------------------------------
  // state
  // --------------------------------------------------
  ise_state_t state_r;
  ise_state_t state_nxt;
  logic [12:0] pc_r;
  logic [12:0] pc_nxt;
  logic [13:0] ir_r;
  logic flush_r;
  logic flush_nxt;
  logic pend_r;
  logic pend_nxt;
  logic [6:0] rdAddr_r;
  logic we_r;
  logic [6:0] wAddr_r;
  logic [7:0] wData_r;
  logic [7:0] acc_r;
  logic zero_r;
  logic push_r;
  logic [12:0] pushData_r;
  logic dWe_r;
  logic [2:0] dSel_r;
  logic [7:0] dData_r;
  logic run_r;
  logic gie_r;
  logic [4:0] latch_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // --------------------------------------------------
  // decode
  // --------------------------------------------------
  ise_op_t op;
  wire exec;
  wire fwd;
  wire [7:0] fVal;
  wire [7:0] aluRes;
  wire aluZUpd;
  wire skip;
  wire toReg;
  wire toAcc;
  wire branch;
  wire vecNow;
  wire [12:0] target;
  wire [12:0] pcInc;
  wire [12:0] seqPc;

  assign exec = (state_r == ISE_EXEC);
  // a flushed word executes as a no-operation
  assign op = flush_r ? ISE_OP_NOP : iseDecode(ir_r);
  // a write still in flight to the same register wins over the file
  assign fwd = we_r && (wAddr_r == rdAddr_r);
  assign fVal = fwd ? wData_r : regRdData;
  assign toReg = (op == ISE_OP_CLEAR) || (iseHasDest(op) && ir_r[7]);
  assign toAcc = (op == ISE_OP_XOR_LIT) || (iseHasDest(op) && !ir_r[7]);
  assign branch = (op == ISE_OP_CALL) || (op == ISE_OP_JUMP);
  assign target = {latch_r[4:3], ir_r[10:0]};
  assign pcInc = pc_r + ISE_PC_STEP;
  assign seqPc = branch ? target : (skip ? pcInc : pc_r);
  // a call and the vector would both push, so the vector waits
  assign vecNow = pend_r && !flush_r && (op != ISE_OP_CALL);

  ise_alu u_alu (
    .op(op),
    .fVal(fVal),
    .acc(acc_r),
    .bitSel(ir_r[9:7]),
    .lit(ir_r[7:0]),
    .res(aluRes),
    .zUpd(aluZUpd),
    .skip(skip)
  );

  // --------------------------------------------------
  // sequencer
  // --------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    pend_nxt = pend_r;
    flush_nxt = flush_r;
    unique case (state_r)
      ISE_IDLE: begin
        if (run_r) begin
          state_nxt = ISE_EXEC;
          flush_nxt = 1'b1;
        end
      end
      ISE_EXEC: begin
        flush_nxt = vecNow || branch || skip;
        if (vecNow) begin
          pc_nxt = ISE_IRQ_VECTOR;
          pend_nxt = 1'b0;
        end else if (!run_r) begin
          pc_nxt = seqPc;
        end else begin
          pc_nxt = branch ? target : pcInc;
        end
        if (op == ISE_OP_SLEEP) begin
          state_nxt = ISE_SLEEP;
        end else if (!run_r) begin
          state_nxt = ISE_IDLE;
        end
      end
      ISE_SLEEP: begin
        if (wakeIrq) begin
          state_nxt = ISE_EXEC;
          pend_nxt = gie_r;
        end
      end
      default: begin
        state_nxt = ISE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ISE_IDLE;
      pc_r <= ISE_RESET_PC;
      pend_r <= 1'b0;
      flush_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      pend_r <= pend_nxt;
      flush_r <= flush_nxt;
    end
  end

  // fetch holds during sleep so the word after sleep runs on wake
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ir_r <= 14'h0000;
      rdAddr_r <= 7'h00;
    end else if (exec) begin
      ir_r <= progWord;
      rdAddr_r <= progWord[6:0];
    end
  end

  // --------------------------------------------------
  // datapath results
  // --------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      we_r <= 1'b0;
      wAddr_r <= 7'h00;
      wData_r <= 8'h00;
    end else begin
      we_r <= exec && toReg;
      wAddr_r <= rdAddr_r;
      wData_r <= aluRes;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_r <= ISE_ACC_RST;
      zero_r <= 1'b0;
    end else begin
      if (exec && toAcc) acc_r <= aluRes;
      if (exec && aluZUpd) zero_r <= (aluRes == 8'h00);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      push_r <= 1'b0;
      pushData_r <= ISE_RESET_PC;
    end else begin
      push_r <= exec && ((op == ISE_OP_CALL) || vecNow);
      pushData_r <= vecNow ? seqPc : pc_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dWe_r <= 1'b0;
      dSel_r <= 3'h0;
      dData_r <= 8'h00;
    end else begin
      dWe_r <= exec && (op == ISE_OP_DIR_LOAD);
      dSel_r <= ir_r[2:0];
      dData_r <= acc_r;
    end
  end

  assign progAddr = pc_r;
  assign regAddr = rdAddr_r;
  assign regWe = we_r;
  assign regWrAddr = wAddr_r;
  assign regWrData = wData_r;
  assign stackPush = push_r;
  assign stackData = pushData_r;
  assign dirWe = dWe_r;
  assign dirSel = dSel_r;
  assign dirData = dData_r;

  // --------------------------------------------------
  // apb slave
  // --------------------------------------------------
  wire apbSetup;
  wire apbWr;
  wire rdOk;
  wire wrOk;
  logic [31:0] rdMux;

  assign apbSetup = psel && !penable;
  assign apbWr = psel && penable && pwrite && pready_r && !pslverr_r;
  assign wrOk = (paddr == ISE_OFS_CTRL) || (paddr == ISE_OFS_LATCH);
  assign rdOk = wrOk || (paddr == ISE_OFS_ACCUM) || (paddr == ISE_OFS_STAT);

  always_comb begin
    rdMux = 32'h0000_0000;
    if (paddr == ISE_OFS_CTRL) begin
      rdMux[ISE_CTRL_RUN] = run_r;
      rdMux[ISE_CTRL_GIE] = gie_r;
    end else if (paddr == ISE_OFS_LATCH) begin
      rdMux[4:0] = latch_r;
    end else if (paddr == ISE_OFS_ACCUM) begin
      rdMux[7:0] = acc_r;
    end else if (paddr == ISE_OFS_STAT) begin
      rdMux[12:0] = pc_r;
      rdMux[ISE_STAT_ZERO] = zero_r;
      rdMux[ISE_STAT_SLEEP] = (state_r == ISE_SLEEP);
    end
  end

  // one wait-free access phase; read data sampled at setup
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= apbSetup;
      pslverr_r <= apbSetup && (pwrite ? !wrOk : !rdOk);
      if (apbSetup && !pwrite) prdata_r <= rdMux;
    end
  end

  // software write to the enable wins over the clear by the vector
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_r <= 1'b0;
      gie_r <= 1'b0;
      latch_r <= ISE_LATCH_RST;
    end else begin
      if (exec && vecNow) gie_r <= 1'b0;
      if (apbWr && paddr == ISE_OFS_CTRL) begin
        run_r <= pwdata[ISE_CTRL_RUN];
        gie_r <= pwdata[ISE_CTRL_GIE];
      end
      if (apbWr && paddr == ISE_OFS_LATCH) latch_r <= pwdata[4:0];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  wire plainExec = exec && !pend_r && run_r;

  sequence wakeWithIrq;
    state_r == ISE_SLEEP && wakeIrq && gie_r;
  endsequence

  sequence wakeNoIrq;
    state_r == ISE_SLEEP && wakeIrq && !gie_r;
  endsequence

  test_skip_a: assert property (
    plainExec && op == ISE_OP_TEST_BIT && fVal[ir_r[9:7]]
    |=> flush_r && pc_r == $past(pcInc)
  ) else $error("set bit did not discard the next word");

  call_push_a: assert property (
    plainExec && op == ISE_OP_CALL
    |=> stackPush && stackData == $past(pc_r) && pc_r == $past(target) && flush_r
  ) else $error("call did not push return address and load target");

  jump_load_a: assert property (
    plainExec && op == ISE_OP_JUMP
    |=> !stackPush && flush_r && pc_r == {$past(latch_r[4:3]), $past(ir_r[10:0])}
  ) else $error("jump loaded a wrong target or pushed");

  clear_zero_a: assert property (
    exec && op == ISE_OP_CLEAR
    |=> regWe && regWrData == 8'h00 && zero_r
  ) else $error("clear did not write zero and set the flag");

  dec_skip_a: assert property (
    plainExec && op == ISE_OP_DEC_SKIP
    |=> $stable(zero_r) && regWrData == $past(fVal) - 8'h01
        && flush_r == ($past(fVal) == 8'h01)
  ) else $error("decrement skip or flags wrong");

  dest_acc_a: assert property (
    exec && iseHasDest(op) && !ir_r[7]
    |=> !regWe && acc_r == regWrData
  ) else $error("destination zero did not go to the accumulator");

  inc_wrap_a: assert property (
    exec && op == ISE_OP_INC && ir_r[7] && fVal == 8'hff
    |=> regWe && regWrData == 8'h00 && zero_r
  ) else $error("increment did not wrap to zero");

  swap_nibble_a: assert property (
    exec && op == ISE_OP_SWAP
    |=> $stable(zero_r) && regWrData == {$past(fVal[3:0]), $past(fVal[7:4])}
  ) else $error("swap result or flag wrong");

  dir_load_a: assert property (
    exec && op == ISE_OP_DIR_LOAD
    |=> dirWe && dirData == $past(acc_r) && dirSel >= 3'h5 && $stable(zero_r)
  ) else $error("direction load wrong");

  xor_lit_a: assert property (
    exec && op == ISE_OP_XOR_LIT
    |=> acc_r == ($past(acc_r) ^ $past(ir_r[7:0])) && zero_r == (acc_r == 8'h00)
  ) else $error("xor literal wrong");

  xor_reg_a: assert property (
    exec && op == ISE_OP_XOR_REG && ir_r[7]
    |=> regWe && regWrData == ($past(acc_r) ^ $past(fVal)) && zero_r == (regWrData == 8'h00)
  ) else $error("xor register wrong");

  wake_vector_a: assert property (
    wakeWithIrq ##1 run_r |-> ##[1:4] pc_r == ISE_IRQ_VECTOR
  ) else $error("enabled wake did not reach the vector");

  wake_inline_a: assert property (
    wakeNoIrq |=> exec && !pend_r && !flush_r
  ) else $error("disabled wake did not continue in line");

  class_decode_a: assert property (
    branch |-> ir_r[13:12] == 2'h2
  ) else $error("branch decoded outside its class");

endmodule

`default_nettype wire

// ---- ise_far.sv ----
// far-side model: program memory, data register file, stack and direction registers
// assumes the core reads both memories combinationally and writes on regWe edges
`timescale 1ns/1ps
`default_nettype none

module ise_far (
  input wire logic clk_sys,
  input wire logic [12:0] progAddr,
  output logic [13:0] progWord,
  input wire logic [6:0] regAddr,
  output logic [7:0] regRdData,
  input wire logic regWe,
  input wire logic [6:0] regWrAddr,
  input wire logic [7:0] regWrData,
  input wire logic stackPush,
  input wire logic [12:0] stackData,
  input wire logic dirWe,
  input wire logic [2:0] dirSel,
  input wire logic [7:0] dirData
);
  logic [13:0] prog [0:8191];
  logic [7:0] regs [0:127];
  logic [7:0] dirs [0:7];
  logic [12:0] lastPush;
  int pushCount = 0;

  assign progWord = prog[progAddr];
  assign regRdData = regs[regAddr];

  // --------------------------------------------------
  // writes land at the edge that carries the strobe
  // --------------------------------------------------
  always @(posedge clk_sys) begin
    if (regWe) regs[regWrAddr] <= regWrData;
    if (stackPush) begin
      lastPush <= stackData;
      pushCount <= pushCount + 1;
    end
    if (dirWe) dirs[dirSel] <= dirData;
  end
endmodule

`default_nettype wire

// ---- tb.sv ----
// self-checking bench: runs short programs through the core and checks results
// assumes the far-side model answers memory reads in the same cycle
`timescale 1ns/1ps
`default_nettype none

module tb
  import ise_pkg::*;
;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, wakeIrq;
  logic [7:0] paddr, regRdData, regWrData, dirData;
  logic [31:0] pwdata, prdata;
  logic [12:0] progAddr, stackData;
  logic [13:0] progWord;
  logic [6:0] regAddr, regWrAddr;
  logic regWe, stackPush, dirWe;
  logic [2:0] dirSel;
  int failCount = 0;
  int samplesChecked = 0;

  ise_core ise_core_i (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .progAddr, .progWord, .regAddr, .regRdData, .regWe, .regWrAddr,
    .regWrData, .stackPush, .stackData, .dirWe, .dirSel, .dirData, .wakeIrq);
  ise_far ise_far_i (.clk_sys, .progAddr, .progWord, .regAddr, .regRdData, .regWe,
    .regWrAddr, .regWrData, .stackPush, .stackData, .dirWe, .dirSel, .dirData);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // --------------------------------------------------
  // shared tasks
  // --------------------------------------------------
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask

  task automatic prep();
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 8192; i++) ise_far_i.prog[i] = 14'h0000;
    for (int i = 0; i < 8; i++) ise_far_i.dirs[i] = 8'h00;
    ise_far_i.pushCount = 0;
  endtask

  task automatic ld(input int at, input logic [13:0] w[$]);
    foreach (w[i]) ise_far_i.prog[at + i] = w[i];
  endtask

  task automatic go(input logic [4:0] latch, input logic global_irq_enable);
    logic [31:0] q;
    logic e;
    apb(1'b1, ISE_OFS_LATCH, {27'h0, latch}, q, e);
    apb(1'b1, ISE_OFS_CTRL, {30'h0, global_irq_enable, 1'b1}, q, e);
  endtask

  // waits for the closing self-loop, halts the core, reads accumulator and status
  task automatic finish(input logic [12:0] pc, output logic [31:0] a, output logic [31:0] s);
    logic e;
    int n;
    n = 0;
    while (progAddr !== pc && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(progAddr), 32'(pc));
    apb(1'b1, ISE_OFS_CTRL, 32'h0, a, e);
    apb(1'b0, ISE_OFS_ACCUM, 32'h0, a, e);
    apb(1'b0, ISE_OFS_STAT, 32'h0, s, e);
  endtask

  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic t_bus();
    logic [31:0] q;
    logic e;
    prep();
    apb(1'b0, ISE_OFS_ACCUM, 32'h0, q, e);
    chk(q, 32'(ISE_ACC_RST));
    apb(1'b0, ISE_OFS_LATCH, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, ISE_OFS_ACCUM, 32'hff, q, e);
    chk(32'(e), 32'h1);
  endtask

  task automatic t_xor();
    logic [31:0] a, s;
    prep();
    ise_far_i.regs[16] = 8'h0f;
    ise_far_i.regs[17] = 8'h33;
    ld(0, '{14'h3aa5, 14'h0610, 14'h0691, 14'h3aaa, 14'h2804});
    go(5'h00, 1'b0);
    finish(13'h0004, a, s);
    chk(a, 32'h0);
    chk(32'(s[ISE_STAT_ZERO]), 32'h1);
    chk(32'(ise_far_i.regs[17]), 32'h99);
    chk(32'(ise_far_i.regs[16]), 32'h0f);
  endtask

  task automatic t_unary();
    logic [31:0] a, s;
    prep();
    ise_far_i.regs[32] = 8'hff;
    ise_far_i.regs[33] = 8'h5a;
    ise_far_i.regs[34] = 8'h77;
    ise_far_i.regs[35] = 8'h7f;
    ld(0, '{14'h0aa0, 14'h0a23, 14'h01a2, 14'h0ea1, 14'h2804});
    go(5'h00, 1'b0);
    finish(13'h0004, a, s);
    chk(32'(ise_far_i.regs[32]), 32'h00);
    chk(a, 32'h80);
    chk(32'(ise_far_i.regs[35]), 32'h7f);
    chk(32'(ise_far_i.regs[34]), 32'h00);
    chk(32'(ise_far_i.regs[33]), 32'ha5);
    chk(32'(s[ISE_STAT_ZERO]), 32'h1);
  endtask

  task automatic t_skip();
    logic [31:0] a, s;
    prep();
    ise_far_i.regs[48] = 8'h02;
    ise_far_i.regs[49] = 8'h01;
    ise_far_i.regs[50] = 8'h03;
    ld(0, '{14'h1cb0, 14'h3a11, 14'h1c30, 14'h3a22, 14'h3a22, 14'h0bb1, 14'h3a44,
            14'h0bb2, 14'h2808});
    go(5'h00, 1'b0);
    finish(13'h0008, a, s);
    chk(a, 32'h0);
    chk(32'(s[ISE_STAT_ZERO]), 32'h1);
    chk(32'(ise_far_i.regs[49]), 32'h00);
    chk(32'(ise_far_i.regs[50]), 32'h02);
  endtask

  task automatic t_branch();
    logic [31:0] a, s;
    prep();
    ld(0, '{14'h2010, 14'h3a01});
    ld(13'h1810, '{14'h2820, 14'h3a02});
    ld(13'h1820, '{14'h3a5c, 14'h2821});
    go(5'h18, 1'b0);
    finish(13'h1821, a, s);
    chk(a, 32'h5c);
    chk(32'(ise_far_i.lastPush), 32'h1);
    chk(32'(ise_far_i.pushCount), 32'h1);
  endtask

  task automatic t_dir();
    logic [31:0] a, s;
    prep();
    ld(0, '{14'h3a3c, 14'h0065, 14'h0067, 14'h0064, 14'h2804});
    go(5'h00, 1'b0);
    finish(13'h0004, a, s);
    chk(32'(ise_far_i.dirs[5]), 32'h3c);
    chk(32'(ise_far_i.dirs[7]), 32'h3c);
    chk({ise_far_i.dirs[4], ise_far_i.dirs[6]}, 32'h0);
  endtask

  task automatic t_wake(input logic global_irq_enable);
    logic [31:0] a, s;
    logic e;
    int n;
    prep();
    ld(0, '{14'h0063, 14'h3a01, 14'h2802, 14'h0000, 14'h3a80, 14'h2805});
    go(5'h00, global_irq_enable);
    n = 0;
    do begin
      apb(1'b0, ISE_OFS_STAT, 32'h0, s, e);
      n++;
    end while (s[ISE_STAT_SLEEP] !== 1'b1 && n < 20);
    chk(32'(s[ISE_STAT_SLEEP]), 32'h1);
    wakeIrq <= 1'b1;
    @(posedge clk_sys);
    wakeIrq <= 1'b0;
    finish(global_irq_enable ? 13'h0005 : 13'h0002, a, s);
    chk(a, global_irq_enable ? 32'h81 : 32'h01);
    chk(32'(ise_far_i.pushCount), 32'(global_irq_enable));
    if (global_irq_enable) chk(32'(ise_far_i.lastPush), 32'h2);
  endtask

  // --------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wakeIrq = 1'b0;
    t_bus();
    t_xor();
    t_unary();
    t_skip();
    t_branch();
    t_dir();
    t_wake(1'b0);
    t_wake(1'b1);
    endOfTest();
  end

  initial begin
    #2000000;
    failCount++;
    endOfTest();
  end
endmodule

`default_nettype wire
